// ### isse_pkg.sv
// Shared constants of the two-wire slave status engine
package isse_pkg;
	localparam int ADDR_W = 3;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 3'h0;
	localparam logic [ADDR_W-1:0] OFS_STAT = 3'h1;
	localparam logic [ADDR_W-1:0] OFS_OWN = 3'h2;
	localparam logic [ADDR_W-1:0] OFS_DATA = 3'h3;
	localparam logic [ADDR_W-1:0] OFS_AUX = 3'h4;
	localparam logic [2:0] MODE_I2C = 3'h6;
	localparam int CTRL_MODE_LSB = 5;
	localparam int CTRL_EN_BIT = 1;
	localparam logic [7:0] CTRL_RESET = 8'hE0;
	localparam logic [7:0] CTRL_WMASK = 8'hEF;
	localparam logic [7:0] STAT_RESET = 8'h81;
	localparam int ST_DONE = 7;
	localparam int ST_MATCH = 6;
	localparam int ST_BUSY = 5;
	localparam int ST_DIR = 4;
	localparam int ST_ACKO = 3;
	localparam int ST_RW = 2;
	localparam int ST_WAKE = 1;
	localparam int ST_ACKI = 0;
	localparam logic [7:0] OWN_RESET = 8'h00;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int AUX_IRQEN = 0;
	localparam int AUX_TOF = 1;
	localparam logic [3:0] BIT_LAST = 4'h8;
	localparam logic LINE_IDLE = 1'b1;
	typedef enum logic [2:0] {
		ISSE_IDLE, ISSE_ADDR, ISSE_AACK, ISSE_RX, ISSE_RACK,
		ISSE_TX, ISSE_TACK, ISSE_SKIP
	} isse_state_t;
endpackage : isse_pkg

// ### isse_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module isse_sync #(
	parameter int WIDTH = 2
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [WIDTH-1:0] i_pin,
	output logic [WIDTH-1:0] o_level
);
	import isse_pkg::*;
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1_reg <= {WIDTH{LINE_IDLE}};
			s2_reg <= {WIDTH{LINE_IDLE}};
			s3_reg <= {WIDTH{LINE_IDLE}};
		end else begin
			s1_reg <= i_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end
	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_filt
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					o_level[g] <= LINE_IDLE;
				end else if (s2_reg[g] == s3_reg[g]) begin
					o_level[g] <= s3_reg[g];
				end
			end
		end
	endgenerate
endmodule : isse_sync

// ### isse_cond.sv
// Bus edge and START/STOP detector
`timescale 1ns/1ps
module isse_cond (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl_rise,
	output logic o_scl_fall,
	output logic o_start,
	output logic o_stop
);
	import isse_pkg::*;
	logic scl_prev_reg;
	logic sda_prev_reg;
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			scl_prev_reg <= LINE_IDLE;
			sda_prev_reg <= LINE_IDLE;
		end else begin
			scl_prev_reg <= i_scl;
			sda_prev_reg <= i_sda;
		end
	end
	assign o_scl_rise = i_scl & ~scl_prev_reg;
	assign o_scl_fall = ~i_scl & scl_prev_reg;
	assign o_start = scl_prev_reg & i_scl & sda_prev_reg & ~i_sda;
	assign o_stop = scl_prev_reg & i_scl & ~sda_prev_reg & i_sda;
endmodule : isse_cond

// ### isse_top.sv
// Slave-only two-wire interface with status and control registers
`timescale 1ns/1ps
module isse_top (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [isse_pkg::ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_scl,
	output logic o_scl,
	output logic o_scl_oe_n,
	input wire logic i_sda,
	output logic o_sda,
	output logic o_sda_oe_n,
	output logic o_irq,
	output logic o_wake
);
	import isse_pkg::*;
	logic [1:0] lvl;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	logic [7:0] serial_control_reg;
	logic [7:0] bus_status_control;
	logic [7:0] own_address_reg;
	logic [7:0] serial_data_reg;
	logic serial_irq_enable;
	logic timeout_flag;
	isse_state_t state_reg;
	logic [3:0] cnt_reg;
	logic [7:0] sh_reg;
	logic [7:0] tx_reg;
	logic sda_low_reg;
	logic hold_reg;
	logic en_prev_reg;
	logic if_on;
	logic en_rise;
	logic data_wr;
	logic data_rd;
	logic addr_hit;
	logic match_ev;
	logic byte_ev;
	logic rx_byte_ev;

	isse_sync #(
		.WIDTH(2)
	) u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_pin({i_scl, i_sda}),
		.o_level(lvl)
	);

	isse_cond u_cond (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_scl(lvl[1]),
		.i_sda(lvl[0]),
		.o_scl_rise(scl_rise),
		.o_scl_fall(scl_fall),
		.o_start(bus_start),
		.o_stop(bus_stop)
	);

	assign if_on = serial_control_reg[CTRL_EN_BIT] &&
		(serial_control_reg[7:CTRL_MODE_LSB] == MODE_I2C);
	assign en_rise = if_on & ~en_prev_reg;
	assign data_wr = i_wr && (i_addr == OFS_DATA);
	assign data_rd = i_rd && (i_addr == OFS_DATA);
	assign addr_hit = sh_reg[7:1] == own_address_reg[7:1];
	assign match_ev = (state_reg == ISSE_ADDR) && scl_fall &&
		(cnt_reg == BIT_LAST) && addr_hit;
	assign rx_byte_ev = (state_reg == ISSE_RX) && scl_fall &&
		(cnt_reg == BIT_LAST);
	assign byte_ev = rx_byte_ev ||
		((state_reg == ISSE_TACK) && scl_fall);

	// Enable edge tracking
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			en_prev_reg <= 1'b0;
		end else begin
			en_prev_reg <= if_on;
		end
	end

	// Control, address and auxiliary registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			serial_control_reg <= CTRL_RESET;
			own_address_reg <= OWN_RESET;
			serial_irq_enable <= 1'b0;
		end else if (i_wr) begin
			if (i_addr == OFS_CTRL) begin
				serial_control_reg <= i_wdata & CTRL_WMASK;
			end
			if (i_addr == OFS_OWN) begin
				own_address_reg <= i_wdata;
			end
			if (i_addr == OFS_AUX) begin
				serial_irq_enable <= i_wdata[AUX_IRQEN];
			end
		end
	end
	assign timeout_flag = 1'b0;

	// Status flags
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bus_status_control <= STAT_RESET;
		end else begin
			if (i_wr && (i_addr == OFS_STAT)) begin
				bus_status_control[ST_DIR] <= i_wdata[ST_DIR];
				bus_status_control[ST_ACKO] <= i_wdata[ST_ACKO];
				bus_status_control[ST_WAKE] <= i_wdata[ST_WAKE];
			end
			if (en_rise) begin
				bus_status_control[ST_DONE] <= 1'b1;
				bus_status_control[ST_MATCH] <= 1'b0;
				bus_status_control[ST_BUSY] <= 1'b0;
				bus_status_control[ST_RW] <= 1'b0;
				bus_status_control[ST_ACKI] <= 1'b1;
			end else if (if_on) begin
				if (data_rd && !bus_status_control[ST_DIR]) begin
					bus_status_control[ST_DONE] <= 1'b0;
				end
				if (bus_start) begin
					bus_status_control[ST_DONE] <= 1'b0;
					bus_status_control[ST_BUSY] <= 1'b1;
				end
				if (bus_stop) begin
					bus_status_control[ST_DONE] <= 1'b1;
					bus_status_control[ST_BUSY] <= 1'b0;
				end
				if ((state_reg == ISSE_ADDR) && scl_rise) begin
					bus_status_control[ST_DONE] <= 1'b0;
				end
				if ((state_reg == ISSE_ADDR) && scl_fall &&
					(cnt_reg == BIT_LAST)) begin
					bus_status_control[ST_MATCH] <= addr_hit;
				end
				if (match_ev) begin
					bus_status_control[ST_RW] <= sh_reg[0];
					bus_status_control[ST_DONE] <= 1'b1;
				end
				if (((state_reg == ISSE_RX) || (state_reg == ISSE_TX)) &&
					scl_rise) begin
					bus_status_control[ST_DONE] <= 1'b0;
				end
				if (byte_ev) begin
					bus_status_control[ST_DONE] <= 1'b1;
				end
				if ((state_reg == ISSE_TACK) && scl_rise) begin
					bus_status_control[ST_ACKI] <= lvl[0];
				end
			end
		end
	end

	// Data register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			serial_data_reg <= DATA_RESET;
		end else if (rx_byte_ev) begin
			serial_data_reg <= sh_reg;
		end else if (data_wr) begin
			serial_data_reg <= i_wdata;
		end
	end

	// Register read port
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else if (i_rd) begin
			unique case (i_addr)
				OFS_CTRL: o_rdata <= serial_control_reg;
				OFS_STAT: o_rdata <= bus_status_control;
				OFS_OWN: o_rdata <= own_address_reg;
				OFS_DATA: o_rdata <= serial_data_reg;
				OFS_AUX: o_rdata <= {6'h00, timeout_flag, serial_irq_enable};
				default: o_rdata <= 8'h00;
			endcase
		end else begin
			o_rdata <= 8'h00;
		end
	end

	// Clock stretch release by data access
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			hold_reg <= 1'b0;
		end else if (!if_on || bus_start || bus_stop) begin
			hold_reg <= 1'b0;
		end else if (((state_reg == ISSE_AACK) ||
			(state_reg == ISSE_RACK)) && scl_fall) begin
			hold_reg <= 1'b1;
		end else if ((state_reg == ISSE_TACK) && scl_fall &&
			!bus_status_control[ST_ACKI]) begin
			hold_reg <= 1'b1;
		end else if (bus_status_control[ST_DIR] ? data_wr : data_rd) begin
			hold_reg <= 1'b0;
		end
	end

	// Bit sequencer
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg <= ISSE_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			tx_reg <= 8'h00;
			sda_low_reg <= 1'b0;
		end else if (!if_on || bus_stop) begin
			state_reg <= ISSE_IDLE;
			sda_low_reg <= 1'b0;
		end else if (bus_start) begin
			state_reg <= ISSE_ADDR;
			cnt_reg <= 4'h0;
			sda_low_reg <= 1'b0;
		end else begin
			if (data_wr) begin
				tx_reg <= i_wdata;
				if (state_reg == ISSE_TX) begin
					sda_low_reg <= ~i_wdata[7];
				end
			end
			unique case (state_reg)
				ISSE_IDLE, ISSE_SKIP: begin
					sda_low_reg <= 1'b0;
				end
				ISSE_ADDR, ISSE_RX: begin
					if (scl_rise) begin
						sh_reg <= {sh_reg[6:0], lvl[0]};
						cnt_reg <= cnt_reg + 4'h1;
					end else if (scl_fall && (cnt_reg == BIT_LAST)) begin
						cnt_reg <= 4'h0;
						if (state_reg == ISSE_RX) begin
							sda_low_reg <= ~bus_status_control[ST_ACKO];
							state_reg <= ISSE_RACK;
						end else if (addr_hit) begin
							sda_low_reg <= 1'b1;
							state_reg <= ISSE_AACK;
						end else begin
							state_reg <= ISSE_SKIP;
						end
					end
				end
				ISSE_AACK, ISSE_RACK: begin
					if (scl_fall) begin
						cnt_reg <= 4'h0;
						sda_low_reg <= 1'b0;
						if ((state_reg == ISSE_AACK) && bus_status_control[ST_RW]) begin
							state_reg <= ISSE_TX;
						end else begin
							state_reg <= ISSE_RX;
						end
					end
				end
				ISSE_TX: begin
					if (scl_rise) begin
						cnt_reg <= cnt_reg + 4'h1;
					end else if (scl_fall) begin
						if (cnt_reg == BIT_LAST) begin
							sda_low_reg <= 1'b0;
							state_reg <= ISSE_TACK;
						end else begin
							tx_reg <= {tx_reg[6:0], 1'b0};
							sda_low_reg <= ~tx_reg[6];
						end
					end
				end
				ISSE_TACK: begin
					if (scl_fall) begin
						cnt_reg <= 4'h0;
						if (!bus_status_control[ST_ACKI]) begin
							state_reg <= ISSE_TX;
						end else begin
							state_reg <= ISSE_SKIP;
						end
					end
				end
			endcase
		end
	end

	// Interrupt and wake pulses
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
			o_wake <= 1'b0;
		end else begin
			o_irq <= if_on && serial_irq_enable && (match_ev || byte_ev);
			o_wake <= if_on && match_ev && bus_status_control[ST_WAKE];
		end
	end

	// Open-drain pins
	assign o_scl = 1'b0;
	assign o_sda = 1'b0;
	assign o_scl_oe_n = ~hold_reg;
	assign o_sda_oe_n = ~sda_low_reg;
endmodule : isse_top

// ### isse_sva.sv
// Assertion checker for the two-wire slave engine
`timescale 1ns/1ps
module isse_sva (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [isse_pkg::ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic i_scl,
	input wire logic o_scl,
	input wire logic o_scl_oe_n,
	input wire logic i_sda,
	input wire logic o_sda,
	input wire logic o_sda_oe_n,
	input wire logic o_irq,
	input wire logic o_wake
);
	import isse_pkg::*;
	logic dir_reg;
	logic [2:0] acc_reg;
	always_ff @(posedge i_clk) begin
		if (i_rst) dir_reg <= 1'b0;
		else if (i_wr && i_addr == OFS_STAT) dir_reg <= i_wdata[ST_DIR];
	end
	always_ff @(posedge i_clk) begin
		if (i_rst) acc_reg <= 3'h0;
		else acc_reg <= {acc_reg[1:0], i_wr | i_rd};
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_release;
		i_addr == OFS_DATA && (i_wr && dir_reg || i_rd && !dir_reg);
	endsequence
	a_scl_value_low: assert property (o_scl == 1'b0)
		else $error("scl value not low");
	a_sda_value_low: assert property (o_sda == 1'b0)
		else $error("sda value not low");
	a_irq_one_cycle: assert property (o_irq |=> !o_irq)
		else $error("irq pulse too long");
	a_wake_one_cycle: assert property (o_wake |=> !o_wake)
		else $error("wake pulse too long");
	a_stretch_holds: assert property (!o_scl_oe_n && !i_wr && !i_rd &&
		acc_reg == 3'h0 |=> !o_scl_oe_n) else $error("stretch dropped");
	a_stretch_ends: assert property (!o_scl_oe_n ##0 s_release
		|-> ##[1:4] o_scl_oe_n) else $error("stretch not released");
	a_stretch_scl_low: assert property ($fell(o_scl_oe_n) |-> !i_scl)
		else $error("stretch began with scl high");
	a_sda_moves_low: assert property ($changed(o_sda_oe_n) |-> !i_scl)
		else $error("sda moved with scl high");
	a_rdata_quiet: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
		else $error("read data outside slot");
endmodule : isse_sva
bind isse_top isse_sva u_sva (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.i_scl(i_scl), .o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n), .i_sda(i_sda),
	.o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_irq(o_irq), .o_wake(o_wake));

// ### isse_master.sv
// Bus master model facing the slave engine
`timescale 1ns/1ps
module isse_master (
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	int n_to = 0;
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task up;
		int k;
		o_scl = 1'b1;
		for (k = 0; k < 2000 && i_scl !== 1'b1; k++) #10;
		if (i_scl !== 1'b1) n_to++;
	endtask : up
	task bitw(input logic v);
		#40 o_sda = v;
		#40 up();
		#80 o_scl = 1'b0;
	endtask : bitw
	task bitr(output logic v);
		#40 o_sda = 1'b1;
		#40 up();
		#40 v = i_sda;
		#40 o_scl = 1'b0;
	endtask : bitr
	task start;
		#80 o_sda = 1'b0;
		#80 o_scl = 1'b0;
	endtask : start
	task stop;
		#40 o_sda = 1'b0;
		#40 up();
		#80 o_sda = 1'b1;
		#80;
	endtask : stop
	task wbyte(input logic [7:0] b, output logic a);
		for (int i = 7; i >= 0; i--) bitw(b[i]);
		bitr(a);
		#80;
	endtask : wbyte
	task rbyte(output logic [7:0] b, input logic a);
		for (int i = 7; i >= 0; i--) bitr(b[i]);
		bitw(a);
		#80;
	endtask : rbyte
endmodule : isse_master

// ### tb_top.sv
// Self-checking bench for the two-wire slave engine
`timescale 1ns/1ps
module tb_top;
	import isse_pkg::*;
	logic i_clk, i_rst, i_wr, i_rd, a;
	logic [ADDR_W-1:0] i_addr;
	logic [7:0] i_wdata, o_rdata, d;
	logic o_scl, o_scl_oe_n, o_sda, o_sda_oe_n, o_irq, o_wake;
	logic m_scl, m_sda, scl_w, sda_w;
	logic [7:0] rv [6] = '{8'hE0, 8'h81, 8'h00, 8'h00, 8'h00, 8'h00};
	int errors = 0, n_checks = 0, n_irq = 0, n_wake = 0;
	assign scl_w = m_scl & (o_scl_oe_n | o_scl);
	assign sda_w = m_sda & (o_sda_oe_n | o_sda);
	isse_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_scl(scl_w), .o_scl(o_scl), .o_scl_oe_n(o_scl_oe_n), .i_sda(sda_w),
		.o_sda(o_sda), .o_sda_oe_n(o_sda_oe_n), .o_irq(o_irq), .o_wake(o_wake));
	isse_master m (.i_scl(scl_w), .i_sda(sda_w), .o_scl(m_scl), .o_sda(m_sda));
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (o_irq === 1'b1) n_irq++;
		if (o_wake === 1'b1) n_wake++;
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [ADDR_W-1:0] ad, input logic [7:0] v);
		@(posedge i_clk);
		i_addr <= ad;
		i_wdata <= v;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task rc(input logic [ADDR_W-1:0] ad, input logic [7:0] mk, exp);
		@(posedge i_clk);
		i_addr <= ad;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata & mk, exp);
	endtask : rc
	task give_verdict;
		errors += m.n_to;
		$display("checks=%0d errors=%0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	initial begin
		#200000;
		errors++;
		give_verdict();
	end
	initial begin
		i_rst = 1'b1;
		{i_addr, i_wdata, i_wr, i_rd} = '0;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		for (int i = 0; i < 6; i++) rc(3'(i), 8'hFF, rv[i]);
		wr(OFS_CTRL, 8'hD2);
		wr(OFS_OWN, 8'hA5);
		wr(OFS_AUX, 8'h01);
		wr(OFS_STAT, 8'h02);
		rc(OFS_CTRL, 8'hFF, 8'hC2);
		rc(OFS_STAT, 8'hFF, 8'h83);
		m.start();
		rc(OFS_STAT, 8'hA0, 8'h20);
		m.wbyte(8'hA4, a);
		chk({7'h00, a}, 8'h00);
		rc(OFS_STAT, 8'hFF, 8'hE3);
		chk({7'h00, o_scl_oe_n}, 8'h00);
		rc(OFS_DATA, 8'hFF, 8'h00);
		chk({7'h00, o_scl_oe_n}, 8'h01);
		m.wbyte(8'h3C, a);
		chk({7'h00, a}, 8'h00);
		rc(OFS_STAT, 8'h80, 8'h80);
		rc(OFS_DATA, 8'hFF, 8'h3C);
		rc(OFS_STAT, 8'h80, 8'h00);
		wr(OFS_STAT, 8'h0A);
		m.wbyte(8'hC3, a);
		chk({7'h00, a}, 8'h01);
		rc(OFS_DATA, 8'hFF, 8'hC3);
		chk(8'(n_irq), 8'h03);
		m.stop();
		rc(OFS_STAT, 8'hA0, 8'h80);
		m.start();
		m.wbyte(8'hA5, a);
		chk({7'h00, a}, 8'h00);
		rc(OFS_STAT, 8'h44, 8'h44);
		wr(OFS_STAT, 8'h12);
		wr(OFS_DATA, 8'h96);
		m.rbyte(d, 1'b0);
		chk(d, 8'h96);
		rc(OFS_STAT, 8'h91, 8'h90);
		wr(OFS_DATA, 8'h5A);
		m.rbyte(d, 1'b1);
		chk(d, 8'h5A);
		rc(OFS_STAT, 8'h01, 8'h01);
		chk({7'h00, o_sda_oe_n}, 8'h01);
		m.stop();
		m.start();
		m.wbyte(8'h20, a);
		chk({7'h00, a}, 8'h01);
		rc(OFS_STAT, 8'h40, 8'h00);
		chk({7'h00, o_scl_oe_n}, 8'h01);
		m.stop();
		chk(8'(n_wake), 8'h02);
		wr(OFS_CTRL, 8'h00);
		wr(OFS_CTRL, 8'hD2);
		rc(OFS_STAT, 8'hFF, 8'h93);
		give_verdict();
	end
endmodule : tb_top
